//--- design/tup_filt_if.sv
// Carrier between the line path and its glitch filter
`timescale 1ns/10ps
`default_nettype none
interface tup_filt_if #(parameter int unsigned DIV_W = 6);
	logic             raw;
	logic             filt;
	logic [DIV_W-1:0] div;
	modport src (output raw, output div, input filt);
	modport flt (input raw, input div, output filt);
endinterface
`default_nettype wire

//--- design/tup_glitch_filter.sv
// Constant-delay glitch filter for the received line level
`timescale 1ns/10ps
`default_nettype none
module tup_glitch_filter (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_rst,
	// Line level in and out
	tup_filt_if.flt   f
);
	import tup_pkg::*;
	localparam int unsigned W = DIV_W;
	logic [W-1:0] cnt;

	// Level must stand one oversample period; equal delay on both edges
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			cnt    <= '0;
			f.filt <= RST_LINE;
		end
		else if (f.raw == f.filt)
			cnt <= '0;
		else if (cnt >= f.div - W'(1))
		begin
			cnt    <= '0;
			f.filt <= f.raw;
		end
		else
			cnt <= cnt + W'(1);
	end
endmodule
`default_nettype wire

//--- design/tup_pkg.sv
// Shared constants, types and helpers of the transparent line path
package tup_pkg;

	// Clock and line rates
	localparam int unsigned CLK_HZ        = 20_000_000;
	localparam int unsigned CLK_MHZ       = CLK_HZ / 1_000_000;
	localparam int unsigned BAUD_FAST     = 230_400;
	localparam int unsigned BAUD_SLOW     = 38_400;
	localparam int unsigned OVERSAMPLE    = 16;
	localparam int unsigned DIV_W         = 6;
	localparam int unsigned TICK_DIV_FAST = CLK_HZ / (BAUD_FAST * OVERSAMPLE);
	localparam int unsigned TICK_DIV_SLOW = CLK_HZ / (BAUD_SLOW * OVERSAMPLE);

	// Short-circuit timing; times in their own units, cycles derived
	localparam int unsigned T_SHORT_NS      = 20_000;
	localparam int unsigned T_RETRY_US      = 1_000;
	localparam int unsigned T_RESTART_US    = 10_000;
	localparam int unsigned SHORT_CYC_DEF   = (T_SHORT_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RETRY_CYC_DEF   = T_RETRY_US * CLK_MHZ;
	localparam int unsigned RESTART_CYC_DEF = T_RESTART_US * CLK_MHZ;
	localparam int unsigned RETRY_COUNT_DEF = 3;

	// Line frame layout and monitor event width
	localparam int unsigned FRAME_BITS = 11;
	localparam int unsigned START_POS  = 0;
	localparam int unsigned DATA_LSB   = 1;
	localparam int unsigned DATA_MSB   = 8;
	localparam int unsigned PARITY_POS = 9;
	localparam int unsigned STOP_POS   = 10;
	localparam int unsigned HALF_TICKS = OVERSAMPLE / 2;
	localparam int unsigned MON_W      = 4;

	// Values after reset
	localparam logic RST_PIN       = 1'b0;
	localparam logic RST_MOSI_HOLD = 1'b1;
	localparam logic RST_LINE      = 1'b0;

	typedef enum logic [1:0] {
		SC_DRIVE        = 2'b00,
		SC_SENSE        = 2'b01,
		SC_WAIT_RETRY   = 2'b11,
		SC_WAIT_RESTART = 2'b10
	} tup_short_state_t;

	typedef enum logic [2:0] {
		MODE_LINK_LISTEN = 3'h0,
		MODE_FORBIDDEN   = 3'h1,
		MODE_LINK_PP     = 3'h2,
		MODE_SW_LISTEN   = 3'h3,
		MODE_SW_LOW      = 3'h4,
		MODE_SW_HIGH     = 3'h5,
		MODE_SW_PP       = 3'h6
	} tup_mode_t;

	function automatic tup_mode_t tup_decode_mode(input logic sio, input logic hs,
		input logic ls);
		tup_mode_t m;
		m = MODE_FORBIDDEN;
		if (sio)
			m = hs ? (ls ? MODE_SW_PP : MODE_SW_HIGH) : (ls ? MODE_SW_LOW : MODE_SW_LISTEN);
		else if (hs == ls)
			m = hs ? MODE_LINK_PP : MODE_LINK_LISTEN;
		return m;
	endfunction

	function automatic logic tup_even_parity(input logic [7:0] d);
		return ^d;
	endfunction

endpackage

//--- design/tup_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none
module tup_sync #(
	parameter int unsigned W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	// Data
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta;

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			meta <= RST_VAL;
			o_q  <= RST_VAL;
		end
		else
		begin
			meta <= i_d;
			o_q  <= meta;
		end
	end
endmodule
`default_nettype wire

//--- design/tup_transparent_path.sv
// Transparent line path: pin sharing, output switches, short handling, input path
`timescale 1ns/10ps
`default_nettype none
module tup_transparent_path #(
	parameter int unsigned SHORT_CYC   = tup_pkg::SHORT_CYC_DEF,
	parameter int unsigned RETRY_CYC   = tup_pkg::RETRY_CYC_DEF,
	parameter int unsigned RESTART_CYC = tup_pkg::RESTART_CYC_DEF,
	parameter int unsigned RETRY_COUNT = tup_pkg::RETRY_COUNT_DEF
) (
	// Clock and reset
	input  wire logic                      I_CLK,
	input  wire logic                      I_SYS_RST,
	// Pins from outside
	input  wire logic                      I_SS,
	input  wire logic                      I_MOSI,
	input  wire logic                      I_CQ_RX,
	input  wire logic                      I_SHORT_DET,
	input  wire logic [tup_pkg::MON_W-1:0] I_MON_EVENT,
	// Control bits
	input  wire logic                      I_TRANSPARENT_ENABLE,
	input  wire logic                      I_SWITCHING_OUTPUT_MODE,
	input  wire logic                      I_HIGH_SIDE_ENABLE,
	input  wire logic                      I_LOW_SIDE_ENABLE,
	input  wire logic                      I_BAUD_SELECT,
	// SPI core
	input  wire logic                      I_SPI_MISO,
	output logic                           O_SPI_FREEZE,
	output logic                           O_MISO,
	// Core resets
	output logic                           O_LINK_FSM_RST,
	output logic                           O_PLL_RST,
	// Output stage
	output logic                           O_HS_ON,
	output logic                           O_LS_ON,
	// Status
	output logic                           O_SHORT_REPORT,
	output logic [tup_pkg::MON_W-1:0]      O_MON_EVENT,
	output logic                           O_FRAME_VALID,
	output logic                           O_FRAME_ERROR,
	output logic [7:0]                     O_FRAME_DATA
);
	import tup_pkg::*;

	localparam int unsigned TMR_W = $clog2(RESTART_CYC + 1);
	localparam int unsigned CNT_W = $clog2(RETRY_COUNT + 2);

	logic                 ss_s;
	logic                 mosi_s;
	logic                 cq_s;
	logic                 short_s;
	logic [MON_W-1:0]     mon_s;
	logic                 trns;
	tup_mode_t            mode;
	logic                 drive_mode;
	logic [DIV_W-1:0]     div_cnt;
	logic [DIV_W-1:0]     div_sel;
	logic                 tick;
	logic                 mosi_hold;
	logic                 level_high;
	tup_short_state_t     state;
	tup_short_state_t     next_state;
	logic [TMR_W-1:0]     timer;
	logic [TMR_W-1:0]     next_timer;
	logic [CNT_W-1:0]     attempts;
	logic [CNT_W-1:0]     next_attempts;
	logic                 next_report;
	logic                 next_drive_ok;
	logic                 rx_line;
	logic                 rx_prev;
	logic                 rx_busy;
	logic [3:0]           rx_phase;
	logic [3:0]           rx_idx;
	logic [FRAME_BITS-1:0] rx_frame;

	tup_filt_if #(.DIV_W(DIV_W)) filt_bus ();

	tup_sync #(.W(4 + MON_W), .RST_VAL('0)) u_sync (
		.i_clk (I_CLK),
		.i_rst (I_SYS_RST),
		.i_d   ({I_SS, I_MOSI, I_CQ_RX, I_SHORT_DET, I_MON_EVENT}),
		.o_q   ({ss_s, mosi_s, cq_s, short_s, mon_s})
	);

	assign trns       = I_TRANSPARENT_ENABLE;
	assign mode       = tup_decode_mode(I_SWITCHING_OUTPUT_MODE, I_HIGH_SIDE_ENABLE,
		I_LOW_SIDE_ENABLE);
	assign drive_mode = (mode == MODE_SW_LOW) || (mode == MODE_SW_HIGH) ||
		(mode == MODE_SW_PP) || (mode == MODE_LINK_PP);

	assign div_sel = I_BAUD_SELECT ? DIV_W'(TICK_DIV_FAST) : DIV_W'(TICK_DIV_SLOW);

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST || !trns)
		begin
			div_cnt <= '0;
			tick    <= 1'b0;
		end
		else if (div_cnt >= div_sel - DIV_W'(1))
		begin
			div_cnt <= '0;
			tick    <= 1'b1;
		end
		else
		begin
			div_cnt <= div_cnt + DIV_W'(1);
			tick    <= 1'b0;
		end
	end

	assign filt_bus.raw = cq_s;
	assign filt_bus.div = div_sel;

	tup_glitch_filter u_filter (
		.i_clk (I_CLK),
		.i_rst (I_SYS_RST),
		.f     (filt_bus.flt)
	);

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			O_LINK_FSM_RST <= 1'b0;
			O_PLL_RST      <= 1'b0;
		end
		else
		begin
			O_LINK_FSM_RST <= trns;
			O_PLL_RST      <= trns;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			O_MON_EVENT <= '0;
		else
			O_MON_EVENT <= mon_s;
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
			mosi_hold <= RST_MOSI_HOLD;
		else if (ss_s)
			mosi_hold <= mosi_s;
	end

	assign level_high = ~mosi_hold;

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			O_SPI_FREEZE <= 1'b0;
			O_MISO       <= RST_PIN;
		end
		else
		begin
			O_SPI_FREEZE <= trns && ss_s;
			O_MISO       <= (trns && ss_s) ? ~filt_bus.filt : I_SPI_MISO;
		end
	end

	always_comb
	begin
		next_state    = state;
		next_timer    = timer + TMR_W'(1);
		next_attempts = attempts;
		if (!trns || (mode == MODE_LINK_LISTEN))
		begin
			next_state    = SC_DRIVE;
			next_timer    = '0;
			next_attempts = '0;
		end
		else
		begin
			unique case (state)
				SC_DRIVE:
				begin
					if (short_s && drive_mode)
					begin
						next_state = SC_SENSE;
						next_timer = '0;
					end
					else if (timer >= TMR_W'(SHORT_CYC - 1))
					begin
						// Clean drive long enough forgets old shorts
						next_timer    = timer;
						next_attempts = '0;
					end
				end
				SC_SENSE:
				begin
					if (!short_s)
					begin
						next_state = SC_DRIVE;
						next_timer = '0;
					end
					else if (timer >= TMR_W'(SHORT_CYC - 1))
					begin
						next_timer = '0;
						next_state = (attempts == '0) ? SC_WAIT_RETRY : SC_WAIT_RESTART;
						if (attempts <= CNT_W'(RETRY_COUNT))
							next_attempts = attempts + CNT_W'(1);
					end
				end
				SC_WAIT_RETRY:
				begin
					if (timer >= TMR_W'(RETRY_CYC - 1))
					begin
						next_state = SC_DRIVE;
						next_timer = '0;
					end
				end
				SC_WAIT_RESTART:
				begin
					if (timer >= TMR_W'(RESTART_CYC - 1))
					begin
						next_state = SC_DRIVE;
						next_timer = '0;
					end
				end
			endcase
		end
	end

	assign next_report = ((next_state == SC_WAIT_RETRY) || (next_state == SC_WAIT_RESTART)) &&
		((mode == MODE_LINK_PP) || (next_attempts > CNT_W'(RETRY_COUNT)));
	assign next_drive_ok = trns && !next_report &&
		((next_state == SC_DRIVE) || (next_state == SC_SENSE));

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			state          <= SC_DRIVE;
			timer          <= '0;
			attempts       <= '0;
			O_SHORT_REPORT <= 1'b0;
		end
		else
		begin
			state          <= next_state;
			timer          <= next_timer;
			attempts       <= next_attempts;
			O_SHORT_REPORT <= next_report;
		end
	end

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST)
		begin
			O_HS_ON <= 1'b0;
			O_LS_ON <= 1'b0;
		end
		else
		begin
			O_HS_ON <= next_drive_ok && level_high && ((mode == MODE_SW_HIGH) ||
				(mode == MODE_SW_PP) || (mode == MODE_LINK_PP));
			O_LS_ON <= next_drive_ok && !level_high && ((mode == MODE_SW_LOW) ||
				(mode == MODE_SW_PP) || (mode == MODE_LINK_PP));
		end
	end

	assign rx_line = ~filt_bus.filt;

	always_ff @(posedge I_CLK)
	begin
		if (I_SYS_RST || !trns)
		begin
			rx_prev       <= 1'b1;
			rx_busy       <= 1'b0;
			rx_phase      <= '0;
			rx_idx        <= '0;
			rx_frame      <= '0;
			O_FRAME_VALID <= 1'b0;
			O_FRAME_ERROR <= 1'b0;
			O_FRAME_DATA  <= '0;
		end
		else
		begin
			rx_prev       <= rx_line;
			O_FRAME_VALID <= 1'b0;
			O_FRAME_ERROR <= 1'b0;
			if (!rx_busy)
			begin
				if (rx_prev && !rx_line)
				begin
					rx_busy  <= 1'b1;
					rx_phase <= '0;
					rx_idx   <= '0;
				end
			end
			else if (tick)
			begin
				// Phase wraps at sixteen, so later samples land mid-bit
				rx_phase <= rx_phase + 4'h1;
				if (rx_phase == 4'(HALF_TICKS - 1))
				begin
					rx_frame[rx_idx] <= rx_line;
					rx_idx           <= rx_idx + 4'h1;
					if ((rx_idx == 4'(START_POS)) && rx_line)
						rx_busy <= 1'b0;
					else if (rx_idx == 4'(STOP_POS))
					begin
						rx_busy      <= 1'b0;
						O_FRAME_DATA <= rx_frame[DATA_MSB:DATA_LSB];
						if (rx_line && (tup_even_parity(rx_frame[DATA_MSB:DATA_LSB]) ==
							rx_frame[PARITY_POS]))
							O_FRAME_VALID <= 1'b1;
						else
							O_FRAME_ERROR <= 1'b1;
					end
				end
			end
		end
	end

	// Checks
	property p_core_rst;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		trns |=> (O_LINK_FSM_RST && O_PLL_RST);
	endproperty
	a_core_rst: assert property (p_core_rst) else $error("core not held in reset");

	property p_leave;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!trns ##1 !trns |-> !O_LINK_FSM_RST && !O_SPI_FREEZE && !O_HS_ON && !O_LS_ON;
	endproperty
	a_leave: assert property (p_leave) else $error("transparent path active after exit");

	property p_mon;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!$past(I_SYS_RST, 1) && !$past(I_SYS_RST, 2) && !$past(I_SYS_RST, 3) |->
			O_MON_EVENT == $past(I_MON_EVENT, 3);
	endproperty
	a_mon: assert property (p_mon) else $error("monitor event lost");

	property p_freeze;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		!ss_s |=> $stable(mosi_hold) && !O_SPI_FREEZE;
	endproperty
	a_freeze: assert property (p_freeze) else $error("switch level moved during access");

	property p_miso;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(trns && ss_s) |=> (O_MISO == !$past(filt_bus.filt)) && O_SPI_FREEZE;
	endproperty
	a_miso: assert property (p_miso) else $error("data-out not inverted line level");

	property p_invert;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mode == MODE_SW_PP) && next_drive_ok |=> (O_HS_ON == !$past(mosi_hold)) &&
			(O_LS_ON == $past(mosi_hold));
	endproperty
	a_invert: assert property (p_invert) else $error("path not inverting");

	property p_forbidden;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		(mode == MODE_FORBIDDEN) || (mode == MODE_SW_LISTEN) |=> !O_HS_ON && !O_LS_ON;
	endproperty
	a_forbidden: assert property (p_forbidden) else $error("switch on in non-driving mode");

	property p_off_report;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		O_SHORT_REPORT |-> !O_HS_ON && !O_LS_ON;
	endproperty
	a_off_report: assert property (p_off_report) else $error("switch on while short reported");

	property p_listen_clear;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		trns && (mode == MODE_LINK_LISTEN) |=> state == SC_DRIVE && attempts == '0 &&
			timer == '0 && !O_SHORT_REPORT;
	endproperty
	a_listen_clear: assert property (p_listen_clear) else $error("listen did not clear short");

	property p_link_now;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		trns && (mode == MODE_LINK_PP) && (state == SC_SENSE) && short_s &&
			(timer == TMR_W'(SHORT_CYC - 1)) |=> O_SHORT_REPORT;
	endproperty
	a_link_now: assert property (p_link_now) else $error("link short not reported");

	property p_sio_late;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		O_SHORT_REPORT && ($past(mode) != MODE_LINK_PP) |-> attempts > CNT_W'(RETRY_COUNT);
	endproperty
	a_sio_late: assert property (p_sio_late) else $error("short reported before retries");

	property p_retry_end;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		trns && (mode != MODE_LINK_LISTEN) && (state == SC_WAIT_RETRY) &&
			(timer == TMR_W'(RETRY_CYC - 1)) |=> state == SC_DRIVE;
	endproperty
	a_retry_end: assert property (p_retry_end) else $error("no retry after delay");

	property p_parity;
		@(posedge I_CLK) disable iff (I_SYS_RST)
		O_FRAME_VALID |-> (^{O_FRAME_DATA, $past(rx_frame[PARITY_POS])}) == 1'b0;
	endproperty
	a_parity: assert property (p_parity) else $error("odd parity frame accepted");
endmodule
`default_nettype wire

//--- verif/transparent_uart_path_bench.sv
// Self-checking bench of the transparent line path
`timescale 1ns/10ps
`default_nettype none
module transparent_uart_path_bench;
	import tup_pkg::*;
	localparam int SC    = 8;
	localparam int RC    = 40;
	localparam int RS    = 80;
	localparam int RN    = 2;
	localparam int LIMIT = 40000;
	logic             clk       = 0;
	logic             rst       = 1;
	logic             ss        = 0;
	logic             mosi      = 1;
	logic             short_det = 0;
	logic [MON_W-1:0] mon_in    = '0;
	logic             te        = 0;
	logic             sio       = 0;
	logic             hs        = 0;
	logic             ls        = 0;
	logic             baud      = 1;
	logic             spi_miso  = 0;
	logic             cq;
	logic             freeze, miso, fsm_rst, pll_rst, hs_on, ls_on, rep, fval, ferr;
	logic [MON_W-1:0] mon_out;
	logic [7:0]       fdata;
	int               n_mismatch = 0;
	int               checked    = 0;
	int               cyc        = 0;

	tup_transparent_path #(.SHORT_CYC(SC), .RETRY_CYC(RC), .RESTART_CYC(RS),
		.RETRY_COUNT(RN)) i_tup_transparent_path (
		.I_CLK(clk), .I_SYS_RST(rst), .I_SS(ss), .I_MOSI(mosi), .I_CQ_RX(cq),
		.I_SHORT_DET(short_det), .I_MON_EVENT(mon_in), .I_TRANSPARENT_ENABLE(te),
		.I_SWITCHING_OUTPUT_MODE(sio), .I_HIGH_SIDE_ENABLE(hs), .I_LOW_SIDE_ENABLE(ls),
		.I_BAUD_SELECT(baud), .I_SPI_MISO(spi_miso), .O_SPI_FREEZE(freeze), .O_MISO(miso),
		.O_LINK_FSM_RST(fsm_rst), .O_PLL_RST(pll_rst), .O_HS_ON(hs_on), .O_LS_ON(ls_on),
		.O_SHORT_REPORT(rep), .O_MON_EVENT(mon_out), .O_FRAME_VALID(fval),
		.O_FRAME_ERROR(ferr), .O_FRAME_DATA(fdata));

	tup_line_master i_tup_line_master (.i_clk(clk), .i_baud_select(baud), .o_cq_rx(cq));

	initial
		forever #25 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == LIMIT)
		begin
			n_mismatch++;
			print_verdict;
		end
	end

	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#5;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: return rep;
			1: return miso;
			default: return fval | ferr;
		endcase
	endfunction

	task automatic wait_for(input int s, input logic v, input int max, output int n);
		n = 0;
		while (pick(s) !== v && n < max)
		begin
			tick(1);
			n++;
		end
	endtask

	// Inverting path: data-in low drives the line high
	function automatic logic [1:0] exp_sw(input logic [2:0] c, input logic m);
		if (!c[2] && (c[1] != c[0]))
			return 2'b00;
		return {c[1] & ~m, c[0] & m};
	endfunction

	task automatic drive(input logic [2:0] c, input logic m);
		{sio, hs, ls} = c;
		mosi = m;
		tick(6);
	endtask

	initial
	begin
		int         n;
		int         div;
		int         rises;
		logic [7:0] d;
		logic       prev;
		logic       ok;
		d = 8'($urandom(32'hcd12));
		tick(12);
		rst = 0;
		tick(3);
		check("fsm_rst_idle", 8'(fsm_rst), 8'h0);
		mosi = 1;
		te = 1;
		tick(1);
		check("fsm_rst", 8'(fsm_rst), 8'h1);
		check("pll_rst", 8'(pll_rst), 8'h1);
		repeat (4)
		begin
			spi_miso = 1'($urandom);
			tick(4);
			check("miso_spi", 8'(miso), 8'(spi_miso));
			check("freeze_lo", 8'(freeze), 8'h0);
		end
		ss = 1;
		tick(2);
		check("ss_sync", 8'(freeze), 8'h0);
		tick(2);
		check("freeze_hi", 8'(freeze), 8'h1);
		check("miso_idle", 8'(miso), 8'h1);
		// Every mode code with both data-in levels, then random ones
		for (int i = 0; i < 48; i++)
		begin
			d = (i < 16) ? 8'(i) : 8'($urandom);
			mon_in = d[7:4];
			drive(d[2:0], d[3]);
			check("switches", 8'({hs_on, ls_on}), 8'(exp_sw(d[2:0], d[3])));
			check("side_gate", 8'({hs_on & ~d[1], ls_on & ~d[0]}), 8'h0);
			check("mon", 8'(mon_out), 8'(mon_in));
		end
		drive(3'b011, 0);
		ss = 0;
		tick(4);
		mosi = 1;
		tick(6);
		check("latched", 8'({hs_on, ls_on}), 8'h2);
		mosi = 0;
		tick(2);
		ss = 1;
		drive(3'b011, 1);
		check("released", 8'({hs_on, ls_on}), 8'h1);
		drive(3'b000, 1);
		for (int b = 0; b < 2; b++)
		begin
			baud = b[0];
			div = b ? TICK_DIV_FAST : TICK_DIV_SLOW;
			ok = 1;
			fork
				i_tup_line_master.glitch(div - 2);
				repeat (div + 8)
				begin
					tick(1);
					ok &= miso;
				end
			join
			check("glitch", 8'(ok), 8'h1);
			fork
				i_tup_line_master.glitch(div + 6);
				wait_for(1, 0, div + 6, n);
			join
			check("filt_delay", 8'(n >= div && n < div + 6), 8'h1);
			// Long pulse looks like a start bit; let that frame pass
			tick(180 * div);
		end
		for (int k = 0; k < 4; k++)
		begin
			baud = (k != 3);
			div = baud ? TICK_DIV_FAST : TICK_DIV_SLOW;
			d = (k == 1) ? 8'h00 : 8'($urandom);
			// Let the new rate settle before the model reads it
			tick(1);
			fork
				i_tup_line_master.send(d, k == 2);
			join_none
			wait_for(2, 1, 12 * OVERSAMPLE * div, n);
			check("frame_valid", 8'(fval), 8'(k != 2));
			check("frame_error", 8'(ferr), 8'(k == 2));
			check("frame_data", fdata, d);
			wait fork;
		end
		baud = 1;
		drive(3'b011, 0);
		short_det = 1;
		wait_for(0, 1, SC + 20, n);
		check("rep_pp", 8'(n >= SC && n < SC + 8), 8'h1);
		check("off_rep", 8'({hs_on, ls_on}), 8'h0);
		wait_for(0, 0, RC + 20, n);
		check("retry", 8'(n >= RC - 2 && n < RC + 4), 8'h1);
		wait_for(0, 1, SC + 20, n);
		wait_for(0, 0, RS + 20, n);
		check("restart", 8'(n >= RS - 2 && n < RS + 4), 8'h1);
		wait_for(0, 1, SC + 20, n);
		{sio, hs, ls} = 3'b000;
		short_det = 0;
		tick(2);
		check("clear", 8'(rep), 8'h0);
		tick(RS);
		drive(3'b110, 0);
		short_det = 1;
		rises = 0;
		prev = hs_on;
		n = 0;
		while (rep !== 1'b1 && n < 1000)
		begin
			tick(1);
			n++;
			rises += (hs_on === 1'b1 && prev === 1'b0);
			prev = hs_on;
		end
		check("sw_retries", 8'(rises), 8'(RN));
		check("sw_off", 8'(hs_on), 8'h0);
		{sio, hs, ls} = 3'b000;
		short_det = 0;
		tick(2);
		te = 0;
		tick(1);
		check("fsm_rst_off", 8'(fsm_rst), 8'h0);
		tick(4);
		check("freeze_off", 8'(freeze), 8'h0);
		print_verdict;
	end
endmodule
`default_nettype wire

//--- verif/tup_line_master.sv
// Line master model: frames and glitches on the received line level
`timescale 1ns/10ps
`default_nettype none
module tup_line_master (
	// Clock and rate
	input  wire logic i_clk,
	input  wire logic i_baud_select,
	// Line level, 1 = line high
	output logic      o_cq_rx
);
	import tup_pkg::*;

	// Idle line is low
	initial
		o_cq_rx = 1'b0;

	task automatic hold(input int n);
		repeat (n) @(posedge i_clk);
		#5;
	endtask

	task automatic glitch(input int n);
		o_cq_rx = 1'b1;
		hold(n);
		o_cq_rx = 1'b0;
	endtask

	task automatic send(input logic [7:0] d, input logic bad);
		logic [10:0] f;
		int          bp;
		f = {1'b1, ^d ^ bad, d, 1'b0};
		bp = OVERSAMPLE * (i_baud_select ? TICK_DIV_FAST : TICK_DIV_SLOW);
		for (int i = 0; i < FRAME_BITS; i++)
		begin
			o_cq_rx = ~f[i];
			hold(bp);
		end
	endtask
endmodule
`default_nettype wire
